// ===== hw/fps_pkg.sv
// constants, types and register map of the flash sequencer
// assumes a 32-bit Avalon-MM slave with byte addressing
package fps_pkg;

  // ==========================================================
  // bus and array geometry
  localparam int ARRAY_AW = 15;
  localparam int BUS_AW = 18;
  localparam int SEL_BIT = 17;
  localparam int IDX_LSB = 2;
  localparam int PAGE_AW = 9;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_DIV = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_ST = 8'h0C;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN = 8'h14;

  // ==========================================================
  // command codes
  localparam logic [7:0] CMD_BLANK = 8'h05;
  localparam logic [7:0] CMD_BYTE = 8'h20;
  localparam logic [7:0] CMD_BURST = 8'h25;
  localparam logic [7:0] CMD_PAGE = 8'h40;
  localparam logic [7:0] CMD_MASS = 8'h41;

  // ==========================================================
  // field positions
  localparam int DIV_W = 7;
  localparam int DIV_LOADED_BIT = 7;
  localparam int ST_CBEF = 7;
  localparam int ST_CCF = 6;
  localparam int ST_ACCERR = 5;
  localparam int ST_BLANKFAIL = 4;
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ACCERR = 1;
  localparam int IRQ_BLANKFAIL = 2;
  localparam logic [DIV_W-1:0] DIV_RESET = 7'h00;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  // ==========================================================
  // types
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_DATA, SEQ_CMD, SEQ_RUN} fps_seq_e;

  typedef struct packed {
    logic [7:0] code;
    logic [ARRAY_AW-1:0] addr;
    logic [7:0] data;
  } fps_cmd_s;

endpackage

// ===== hw/fps_sequencer.sv
// flash program/erase command sequencer with its own flash array
// assumes an Avalon-MM master on clk; array words at SEL_BIT set
//
// The Avalon-MM register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps

module fps_sequencer #(
  parameter int PAGE_AW = fps_pkg::PAGE_AW
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [fps_pkg::BUS_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq
);

  localparam int AW = fps_pkg::ARRAY_AW;
  localparam int DEPTH = 1 << AW;
  localparam logic [AW-1:0] LAST_ADDR = AW'(DEPTH - 1);
  localparam logic [AW-1:0] PAGE_MASK = ~AW'((1 << PAGE_AW) - 1);
  localparam int IDX_LSB_END = fps_pkg::IDX_LSB + AW - 1;

  // ==========================================================
  // storage and state
  logic [7:0] mem [DEPTH];
  logic ackQ;
  logic [31:0] rdataQ;
  logic [fps_pkg::DIV_W-1:0] divQ;
  logic divLoadedQ;
  logic [fps_pkg::DIV_W-1:0] divCntQ;
  fps_pkg::fps_seq_e stateQ;
  fps_pkg::fps_seq_e stateD;
  fps_pkg::fps_cmd_s cmdQ;
  logic [AW-1:0] curQ;
  logic [AW-1:0] endQ;
  logic accErrQ;
  logic blankFailQ;
  logic [fps_pkg::IRQ_W-1:0] irqStQ;
  logic [fps_pkg::IRQ_W-1:0] irqEnQ;

  // ==========================================================
  // bus decode
  logic wrEn;
  logic regHit;
  logic arrWr;
  logic cmdWr;
  logic statWr;
  logic [7:0] ofs;
  logic [AW-1:0] idx;
  logic cmdValid;
  logic launch;
  logic seqErr;
  logic tick;
  logic isErase;
  logic isBlank;
  logic done;
  logic blankMiss;
  logic [7:0] regRd;
  logic divWr;
  logic irqClrWr;
  logic irqEnWr;
  logic takeAddr;
  logic takeCode;
  logic [AW-1:0] firstAddr;
  logic [AW-1:0] lastAddr;

  assign ofs = avs_address[7:0];
  assign idx = avs_address[IDX_LSB_END:fps_pkg::IDX_LSB];
  assign regHit = !avs_address[fps_pkg::SEL_BIT]
    && (avs_address[fps_pkg::SEL_BIT-1:8] == '0);
  // write takes effect only at the edge where waitrequest is low
  assign wrEn = avs_write && ackQ && avs_byteenable[0];
  assign arrWr = wrEn && avs_address[fps_pkg::SEL_BIT];
  assign cmdWr = wrEn && regHit && (ofs == fps_pkg::OFS_CMD);
  assign statWr = wrEn && regHit && (ofs == fps_pkg::OFS_STAT);
  assign divWr = wrEn && regHit && (ofs == fps_pkg::OFS_DIV);
  assign irqClrWr = wrEn && regHit && (ofs == fps_pkg::OFS_IRQ_CLR);
  assign irqEnWr = wrEn && regHit && (ofs == fps_pkg::OFS_IRQ_EN);
  assign avs_waitrequest = (avs_read || avs_write) && !ackQ;

  // ==========================================================
  // Avalon answer timing
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ackQ <= 1'b0;
    end else begin
      ackQ <= (avs_read || avs_write) && !ackQ;
    end
  end

  always_comb begin
    regRd = 8'h00;
    case (ofs)
      fps_pkg::OFS_DIV: regRd = {divLoadedQ, divQ};
      fps_pkg::OFS_CMD: regRd = cmdQ.code;
      fps_pkg::OFS_STAT: begin
        regRd[fps_pkg::ST_CBEF] = (stateQ == fps_pkg::SEQ_IDLE);
        regRd[fps_pkg::ST_CCF] = (stateQ != fps_pkg::SEQ_RUN);
        regRd[fps_pkg::ST_ACCERR] = accErrQ;
        regRd[fps_pkg::ST_BLANKFAIL] = blankFailQ;
      end
      fps_pkg::OFS_IRQ_ST: regRd = 8'(irqStQ);
      fps_pkg::OFS_IRQ_EN: regRd = 8'(irqEnQ);
      default: regRd = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdataQ <= 32'h0000_0000;
    end else if (avs_read && !ackQ) begin
      if (avs_address[fps_pkg::SEL_BIT]) begin
        rdataQ <= {24'h00_0000, mem[idx]};
      end else if (regHit) begin
        rdataQ <= {24'h00_0000, regRd};
      end else begin
        rdataQ <= 32'h0000_0000;
      end
    end
  end

  assign avs_readdata = rdataQ;

  // ==========================================================
  // clock divider, loaded once after reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      divQ <= fps_pkg::DIV_RESET;
      divLoadedQ <= 1'b0;
    end else if (divWr && !divLoadedQ) begin
      divQ <= avs_writedata[fps_pkg::DIV_W-1:0];
      divLoadedQ <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      divCntQ <= '0;
    end else if (stateQ != fps_pkg::SEQ_RUN || tick) begin
      divCntQ <= '0;
    end else begin
      divCntQ <= divCntQ + 1'b1;
    end
  end

  assign tick = (stateQ == fps_pkg::SEQ_RUN) && (divCntQ == divQ);

  // ==========================================================
  // command sequence
  always_comb begin
    case (avs_writedata[7:0])
      fps_pkg::CMD_BLANK, fps_pkg::CMD_BYTE, fps_pkg::CMD_BURST: cmdValid = 1'b1;
      fps_pkg::CMD_PAGE, fps_pkg::CMD_MASS: cmdValid = 1'b1;
      default: cmdValid = 1'b0;
    endcase
  end

  assign isErase = (cmdQ.code == fps_pkg::CMD_PAGE) || (cmdQ.code == fps_pkg::CMD_MASS);
  assign isBlank = cmdQ.code == fps_pkg::CMD_BLANK;
  assign done = tick && (curQ == endQ);
  assign takeAddr = (stateQ == fps_pkg::SEQ_IDLE) && arrWr && !accErrQ;
  assign takeCode = (stateQ == fps_pkg::SEQ_DATA) && cmdWr && cmdValid;

  always_comb begin
    stateD = stateQ;
    launch = 1'b0;
    seqErr = 1'b0;
    case (stateQ)
      fps_pkg::SEQ_IDLE: begin
        if (arrWr && !accErrQ) begin
          stateD = fps_pkg::SEQ_DATA;
        end else if (cmdWr) begin
          seqErr = 1'b1;
        end
      end
      fps_pkg::SEQ_DATA: begin
        if (cmdWr && cmdValid) begin
          stateD = fps_pkg::SEQ_CMD;
        end else if (arrWr || cmdWr || statWr) begin
          stateD = fps_pkg::SEQ_IDLE;
          seqErr = 1'b1;
        end
      end
      fps_pkg::SEQ_CMD: begin
        if (statWr && avs_writedata[fps_pkg::ST_CBEF] && divLoadedQ) begin
          stateD = fps_pkg::SEQ_RUN;
          launch = 1'b1;
        end else if (arrWr || cmdWr || statWr) begin
          stateD = fps_pkg::SEQ_IDLE;
          seqErr = 1'b1;
        end
      end
      fps_pkg::SEQ_RUN: begin
        if (done) begin
          stateD = fps_pkg::SEQ_IDLE;
        end
        if (arrWr || cmdWr) begin
          seqErr = 1'b1;
        end
      end
      default: stateD = fps_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stateQ <= fps_pkg::SEQ_IDLE;
    end else begin
      stateQ <= stateD;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmdQ <= '0;
    end else if (takeAddr) begin
      cmdQ.addr <= idx;
      cmdQ.data <= avs_writedata[7:0];
    end else if (takeCode) begin
      cmdQ.code <= avs_writedata[7:0];
    end
  end

  // ==========================================================
  // execution engine, one byte per divided tick
  always_comb begin
    firstAddr = cmdQ.addr;
    lastAddr = cmdQ.addr;
    case (cmdQ.code)
      fps_pkg::CMD_PAGE: begin
        firstAddr = cmdQ.addr & PAGE_MASK;
        lastAddr = cmdQ.addr | ~PAGE_MASK;
      end
      fps_pkg::CMD_MASS, fps_pkg::CMD_BLANK: begin
        firstAddr = '0;
        lastAddr = LAST_ADDR;
      end
      default: begin
        firstAddr = cmdQ.addr;
        lastAddr = cmdQ.addr;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      curQ <= '0;
    end else if (launch) begin
      curQ <= firstAddr;
    end else if (tick && !done) begin
      curQ <= curQ + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      endQ <= '0;
    end else if (launch) begin
      endQ <= lastAddr;
    end
  end

  // programming can only clear bits; erase fills with the erased value
  always_ff @(posedge clk) begin
    if (tick && isErase) begin
      mem[curQ] <= fps_pkg::ERASED_BYTE;
    end else if (tick && !isBlank) begin
      mem[curQ] <= mem[curQ] & cmdQ.data;
    end
  end

  assign blankMiss = tick && isBlank && (mem[curQ] != fps_pkg::ERASED_BYTE);

  // ==========================================================
  // flags, set wins over clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      accErrQ <= 1'b0;
    end else begin
      accErrQ <= seqErr || (accErrQ
        && !(statWr && avs_writedata[fps_pkg::ST_ACCERR]));
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      blankFailQ <= 1'b0;
    end else begin
      blankFailQ <= blankMiss || (blankFailQ
        && !(statWr && avs_writedata[fps_pkg::ST_BLANKFAIL]));
    end
  end

  // ==========================================================
  // interrupts
  logic [fps_pkg::IRQ_W-1:0] irqEv;
  logic [fps_pkg::IRQ_W-1:0] irqClr;

  always_comb begin
    irqEv = '0;
    irqEv[fps_pkg::IRQ_DONE] = done;
    irqEv[fps_pkg::IRQ_ACCERR] = seqErr;
    irqEv[fps_pkg::IRQ_BLANKFAIL] = blankMiss;
  end

  assign irqClr = irqClrWr ? avs_writedata[fps_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irqStQ <= fps_pkg::IRQ_RESET;
    end else begin
      irqStQ <= irqEv | (irqStQ & ~irqClr);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irqEnQ <= fps_pkg::IRQ_RESET;
    end else if (irqEnWr) begin
      irqEnQ <= avs_writedata[fps_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(irqStQ & irqEnQ);

endmodule

// ===== testbench/fps_monitor.sv
// port checker for the flash sequencer
// assumes a bind onto fps_sequencer, one clock domain
`timescale 1ns/1ps
module fps_monitor #(
  parameter int PAGE_AW = 9
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [17:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq
);
  // ====
  // bus steps
  logic req;
  assign req = avs_read | avs_write;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_rd(logic [7:0] o);
    avs_read && !avs_waitrequest && avs_address == {10'h000, o};
  endsequence
  sequence s_wr_en;
    avs_write && !avs_waitrequest && avs_byteenable[0] &&
      avs_address == {10'h000, fps_pkg::OFS_IRQ_EN};
  endsequence
  // ====
  // properties
  property p_one_wait; req && avs_waitrequest |=> !avs_waitrequest; endproperty
  property p_rewait; req && !avs_waitrequest ##1 req |-> avs_waitrequest; endproperty
  property p_no_wait; !req |-> !avs_waitrequest; endproperty
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address == 18'h00018 |-> avs_readdata == 32'h0;
  endproperty
  property p_run_busy; s_rd(fps_pkg::OFS_STAT) ##0 !avs_readdata[6] |-> !avs_readdata[7];
  endproperty
  property p_stat_res;
    s_rd(fps_pkg::OFS_STAT) |-> avs_readdata[3:0] == 4'h0 && avs_readdata[31:8] == 24'h0;
  endproperty
  property p_en_back;
    s_wr_en ##3 s_rd(fps_pkg::OFS_IRQ_EN) |-> avs_readdata[2:0] == $past(avs_writedata[2:0], 3);
  endproperty
  property p_mask; s_wr_en ##0 avs_writedata[2:0] == 3'h0 |=> !irq; endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait not one cycle");
  a_rewait: assert property (p_rewait) else $error("no wait on new request");
  a_no_wait: assert property (p_no_wait) else $error("wait without request");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_run_busy: assert property (p_run_busy) else $error("buffer empty while running");
  a_stat_res: assert property (p_stat_res) else $error("status spare bits set");
  a_en_back: assert property (p_en_back) else $error("irq enable readback");
  a_mask: assert property (p_mask) else $error("irq high while masked");
endmodule
bind fps_sequencer fps_monitor #(.PAGE_AW(PAGE_AW)) mon_u (.clk(clk), .reset_n(reset_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));

// ===== testbench/flash_program_erase_sequencer_test.sv
// self-checking bench for the flash sequencer
// assumes fps_sequencer and fps_pkg compiled first
`timescale 1ns/1ps
module flash_program_erase_sequencer_test;
  // ====
  // stimulus and bus tasks
  localparam logic [17:0] DV = 18'h00000;
  localparam logic [17:0] CM = 18'h00004;
  localparam logic [17:0] ST = 18'h00008;
  localparam logic [17:0] IS = 18'h0000C;
  localparam logic [17:0] IC = 18'h00010;
  localparam logic [17:0] IE = 18'h00014;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [17:0] avs_address = 18'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  int errors = 0;
  int checkCount = 0;
  fps_sequencer dut_u (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  always #25 clk = ~clk;
  function automatic logic [17:0] arr(input logic [14:0] i);
    return {1'b1, i, 2'b00};
  endfunction
  task automatic complete_run;
    if (errors == 0 && checkCount > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checkCount++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [17:0] a, input logic [7:0] d,
      output logic [31:0] q);
    @(posedge clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    do begin
      @(negedge clk);
    end while (avs_waitrequest !== 1'b0);
    @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [17:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 8'h00, q);
    chk("readdata", e, q);
  endtask
  task automatic ck_irq(input logic e);
    @(negedge clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  task automatic run(input logic [7:0] c, input logic [14:0] i, input logic [7:0] d);
    logic [31:0] q;
    wr(arr(i), d);
    wr(CM, c);
    wr(ST, 8'h80);
    do begin
      acc(1'b0, ST, 8'h00, q);
    end while (q[6] !== 1'b1);
  endtask
  // ====
  // tests
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    rc(ST, 32'hC0);
    rc(DV, 32'h00);
    wr(arr(15'h0010), 8'h00);
    wr(CM, 8'h20);
    wr(ST, 8'h80);
    rc(ST, 32'hE0);
    rc(IS, 32'h02);
    ck_irq(1'b0);
    wr(IE, 8'h07);
    rc(IE, 32'h07);
    ck_irq(1'b1);
    wr(IC, 8'h07);
    ck_irq(1'b0);
    wr(ST, 8'h20);
    rc(ST, 32'hC0);
    wr(DV, 8'h00);
    wr(DV, 8'h05);
    rc(DV, 32'h80);
    run(8'h41, 15'h1234, 8'h00);
    run(8'h05, 15'h7FFF, 8'h00);
    rc(ST, 32'hC0);
    rc(IS, 32'h01);
    ck_irq(1'b1);
    wr(IE, 8'h00);
    ck_irq(1'b0);
    wr(IE, 8'h07);
    wr(IC, 8'h07);
    run(8'h20, 15'h0010, 8'h5A);
    run(8'h25, 15'h01FF, 8'h3C);
    run(8'h20, 15'h0200, 8'h11);
    rc(arr(15'h0010), 32'h5A);
    rc(arr(15'h01FF), 32'h3C);
    run(8'h40, 15'h0123, 8'h00);
    rc(arr(15'h0010), 32'hFF);
    rc(arr(15'h01FF), 32'hFF);
    rc(arr(15'h0200), 32'h11);
    wr(arr(15'h0200), 8'h00);
    wr(ST, 8'h00);
    rc(ST, 32'hE0);
    run(8'h20, 15'h0201, 8'h00);
    rc(arr(15'h0201), 32'hFF);
    rc(arr(15'h0200), 32'h11);
    wr(ST, 8'h20);
    wr(arr(15'h0300), 8'h00);
    wr(CM, 8'h33);
    rc(ST, 32'hE0);
    rc(arr(15'h0300), 32'hFF);
    wr(ST, 8'h20);
    wr(CM, 8'h20);
    rc(ST, 32'hE0);
    wr(ST, 8'h20);
    rc(ST, 32'hC0);
    avs_byteenable <= 4'hE;
    wr(CM, 8'h20);
    avs_byteenable <= 4'hF;
    rc(ST, 32'hC0);
    rc(18'h00018, 32'h0);
    complete_run();
  end
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    complete_run();
  end
endmodule
